// >>> cssr_pkg.sv
// Package for the clock switch status and control register block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package cssr_pkg;
   // Byte addresses of the registers; each takes one aligned word.
   localparam logic [7:0] CSSR_REQ_OFF      = 8'h00;  // Requested source and divider.
   localparam logic [7:0] CSSR_CUR_OFF      = 8'h04;  // Current clock setting.
   localparam logic [7:0] CSSR_CTL_OFF      = 8'h08;  // Clock switch control.
   localparam logic [7:0] CSSR_STAT_OFF     = 8'h0C;  // Oscillator ready status.
   localparam logic [7:0] CSSR_EN_OFF       = 8'h10;  // Oscillator force enable.
   localparam logic [7:0] CSSR_CFG_OFF      = 8'h14;  // Frequency, mode and irq enable.
   localparam logic [7:0] CSSR_IRQ_OFF      = 8'h18;  // Switch interrupt flag.
   // Field positions.
   localparam int CSSR_SRC_LSB  = 4;
   localparam int CSSR_HOLD_BIT = 7;
   localparam int CSSR_DONE_BIT = 4;
   localparam int CSSR_NEW_BIT  = 3;
   localparam int CSSR_EXT_BIT  = 7;
   localparam int CSSR_HF_BIT   = 6;
   localparam int CSSR_MF_BIT   = 5;
   localparam int CSSR_LF_BIT   = 4;
   localparam int CSSR_RC_BIT   = 2;
   localparam int CSSR_PLL_BIT  = 0;
   localparam int CSSR_IE_BIT   = 8;
   // Writable bit masks of the force enable register.
   localparam logic [7:0] CSSR_EN_MASK      = 8'hF4;
   // Source encodings.
   localparam logic [2:0] CSSR_SRC_EXT      = 3'h7;
   localparam logic [2:0] CSSR_SRC_HF       = 3'h6;
   localparam logic [2:0] CSSR_SRC_LF       = 3'h5;
   localparam logic [2:0] CSSR_SRC_EXT_PLL  = 3'h2;
   localparam logic [2:0] CSSR_SRC_HF_PLL   = 3'h1;
   localparam logic [3:0] CSSR_DIV_MAX      = 4'h9;
   // Reset values.
   localparam logic [2:0] CSSR_RST_SRC      = 3'h6;
   localparam logic [3:0] CSSR_RST_DIV_HF   = 4'h2;
   localparam logic [3:0] CSSR_RST_DIV      = 4'h0;
   localparam logic [7:0] CSSR_RST_EN       = 8'h00;
   localparam logic [2:0] CSSR_RST_FRQ      = 3'h2;
   localparam logic [2:0] CSSR_RST_MODE     = 3'h0;
   // AXI responses.
   localparam logic [1:0] CSSR_OKAY         = 2'h0;
   localparam logic [1:0] CSSR_SLVERR       = 2'h2;
   // One clock setting: source and divider.
   typedef struct packed {
      logic [2:0] src;
      logic [3:0] div;
   } cssr_setting_t;
   // Raw ready indications from the oscillators and PLL.
   typedef struct packed {
      logic ext;
      logic hf;
      logic mf;
      logic lf;
      logic rc;
      logic pll;
   } cssr_ready_t;
   // Switch sequencer states.
   typedef enum logic [1:0] {CSSR_IDLE, CSSR_WAIT, CSSR_HELD} cssr_state_t;
endpackage

// >>> cssr_top.sv
// Clock switch status and control registers with an AXI4-Lite slave.
// Assumes oscillator ready inputs are asynchronous and the mux obeys active_sel.
//
// Overview of operation
// - Current source field read-only at bits 6-4.
// - Current divider field read-only at bits 3-0.
// - Reset: current fields equal requested fields.
// - Power-on current fields show starting setting.
// - Source codes 7,6,5,2,1 valid; others reserved.
// - Divider is two to code; above nine reserved.
// - HF frequency and external mode come from config.
// - Hold bit stalls ready switch, raising interrupt.
// - Hold clear at ready: switch takes place.
// - Done flag set when request equals current.
// - New-ready flag: switch held and requested oscillator ready.
// - Status ready flags at bits 7,6,5,4,2.
// - PLL flag needs enable, input ready, lock.
// - Bit 7 forces external oscillator on.
// - Bit 6 forces high-frequency internal on.
// - Bits 5,4,2 force mid, low, converter on.
// - Unimplemented bits ignore writes, read zero.
// - Current fields change only when switch occurs.
// - Reserved source write discards whole request.
// - Interrupt flag sets when requested oscillator ready, held or not; enable gates.
`timescale 1ns/100ps
module cssr_top
   import cssr_pkg::*;
(
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          rst_n,
   // AXI4-Lite write address and data.
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   // AXI4-Lite read channels.
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   // Oscillator side.
   input  wire cssr_ready_t   osc_ready_raw,
   input  wire logic          pll_enabled,
   input  wire logic          pll_locked,
   output cssr_setting_t      active_sel,
   output logic [2:0]         pll_input_src,
   output logic [7:0]         osc_force_on,
   output logic [2:0]         internal_freq_sel,
   output logic [2:0]         ext_osc_mode_cfg,
   output logic               switch_irq
);
   logic          rst_s1_r, rst_sync_n;  // Reset release synchroniser.
   cssr_ready_t   rdy_s1_r, rdy_r;       // Ready input synchroniser.
   logic          pllen_s1_r, pllen_r;   // PLL enable synchroniser.
   logic          lock_s1_r, lock_r;     // PLL lock synchroniser.
   cssr_setting_t req_r;                 // Requested setting.
   cssr_setting_t cur_r;                 // Current setting.
   logic          hold_r;                // Switch hold bit.
   logic          new_rdy_r;             // New oscillator ready flag.
   logic          irq_flag_r;            // Switch interrupt flag.
   logic          irq_en_r;              // Switch interrupt enable.
   logic [7:0]    en_r;                  // Force enable register.
   logic [2:0]    frq_r;                 // Internal frequency select.
   logic [2:0]    mode_r;                // External oscillator mode.
   cssr_state_t   state_r;               // Switch sequencer state.
   logic          aw_hit_r, w_hit_r;     // Address and data taken.
   logic [7:0]    awaddr_r;              // Latched write address.
   logic [31:0]   wdata_r;               // Latched write data.
   logic [3:0]    wstrb_r;               // Latched byte strobes.
   logic          wr_go;                 // Write commits this cycle.
   logic          req_rdy;               // Requested oscillator ready.
   logic          pll_ok;                // PLL usable.
   logic          src_ok;                // Written source code legal.
   logic          ready_rise;            // New oscillator becomes ready.
   logic          clr_irq;               // Software clears the flag.
   logic [7:0]    stat_byte;             // Status register image.
   logic [31:0]   rd_word;               // Read mux output.
   logic          rd_ok;                 // Read address mapped.

   // Reset is released through two flops so removal is synchronous.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_r   <= 1'b1;
         rst_sync_n <= rst_s1_r;
      end
   end

   // Ready lines come from other clocks; only the second stage is read.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdy_s1_r   <= '0;
         rdy_r      <= '0;
         pllen_s1_r <= 1'b0;
         pllen_r    <= 1'b0;
         lock_s1_r  <= 1'b0;
         lock_r     <= 1'b0;
      end else begin
         rdy_s1_r   <= osc_ready_raw;
         rdy_r      <= rdy_s1_r;
         pllen_s1_r <= pll_enabled;
         pllen_r    <= pllen_s1_r;
         lock_s1_r  <= pll_locked;
         lock_r     <= lock_s1_r;
      end
   end

   // The PLL counts as usable only with its input, enable and lock.
   always_comb begin
      case (pll_input_src)
         CSSR_SRC_EXT: pll_ok = pllen_r && lock_r && rdy_r.ext;
         CSSR_SRC_HF:  pll_ok = pllen_r && lock_r && rdy_r.hf;
         default:      pll_ok = 1'b0;
      endcase
   end

   // Readiness of whatever the request selects.
   always_comb begin
      case (req_r.src)
         CSSR_SRC_EXT:     req_rdy = rdy_r.ext;
         CSSR_SRC_HF:      req_rdy = rdy_r.hf;
         CSSR_SRC_LF:      req_rdy = rdy_r.lf;
         CSSR_SRC_EXT_PLL: req_rdy = rdy_r.ext && pll_ok;
         CSSR_SRC_HF_PLL:  req_rdy = rdy_r.hf && pll_ok;
         default:          req_rdy = 1'b0;
      endcase
   end

   // Source code check for request writes.
   always_comb begin
      case (wdata_r[CSSR_SRC_LSB +: 3])
         CSSR_SRC_EXT, CSSR_SRC_HF, CSSR_SRC_LF,
         CSSR_SRC_EXT_PLL, CSSR_SRC_HF_PLL: src_ok = 1'b1;
         default:                           src_ok = 1'b0;
      endcase
   end

   assign wr_go      = aw_hit_r && w_hit_r && !s_axi_bvalid;
   // Only a real pending switch may raise the flag, not a request already met.
   assign ready_rise = (state_r == CSSR_WAIT) && req_rdy && (req_r != cur_r);
   assign clr_irq    = wr_go && (awaddr_r == CSSR_IRQ_OFF) && wstrb_r[0] && wdata_r[0];

   // Request register; reserved source codes drop the entire write.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         req_r.src <= CSSR_RST_SRC;
         req_r.div <= CSSR_RST_DIV_HF;
      end else if (wr_go && awaddr_r == CSSR_REQ_OFF && wstrb_r[0] && src_ok
                   && wdata_r[3:0] <= CSSR_DIV_MAX) begin
         req_r.src <= wdata_r[CSSR_SRC_LSB +: 3];
         req_r.div <= wdata_r[3:0];
      end
   end

   // Sequencer: waits for the new oscillator, then switches or holds.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_r   <= CSSR_IDLE;
         cur_r.src <= CSSR_RST_SRC;
         cur_r.div <= CSSR_RST_DIV_HF;
         new_rdy_r <= 1'b0;
      end else begin
         case (state_r)
            CSSR_IDLE: begin
               new_rdy_r <= 1'b0;
               if (req_r != cur_r) begin
                  state_r <= CSSR_WAIT;
               end
            end
            CSSR_WAIT: begin
               if (req_r == cur_r) begin
                  state_r <= CSSR_IDLE;
               end else if (req_rdy && !hold_r) begin
                  cur_r   <= req_r;
                  state_r <= CSSR_IDLE;
               end else if (req_rdy) begin
                  new_rdy_r <= 1'b1;
                  state_r   <= CSSR_HELD;
               end
            end
            CSSR_HELD: begin
               // Software abandons by copying current into the request.
               if (req_r == cur_r) begin
                  new_rdy_r <= 1'b0;
                  state_r   <= CSSR_IDLE;
               end else if (!req_rdy) begin
                  new_rdy_r <= 1'b0;
                  state_r   <= CSSR_WAIT;
               end else if (!hold_r) begin
                  cur_r     <= req_r;
                  new_rdy_r <= 1'b0;
                  state_r   <= CSSR_IDLE;
               end
            end
            default: state_r <= CSSR_IDLE;
         endcase
      end
   end

   // Interrupt flag; a new event wins over a software clear.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_flag_r <= 1'b0;
      end else if (ready_rise) begin
         irq_flag_r <= 1'b1;
      end else if (clr_irq) begin
         irq_flag_r <= 1'b0;
      end
   end

   // Software-written control: hold, force enables, config and irq enable.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_r   <= 1'b0;
         en_r     <= CSSR_RST_EN;
         frq_r    <= CSSR_RST_FRQ;
         mode_r   <= CSSR_RST_MODE;
         irq_en_r <= 1'b0;
      end else if (wr_go) begin
         if (awaddr_r == CSSR_CTL_OFF && wstrb_r[0]) begin
            hold_r <= wdata_r[CSSR_HOLD_BIT];
         end
         if (awaddr_r == CSSR_EN_OFF && wstrb_r[0]) begin
            en_r <= wdata_r[7:0] & CSSR_EN_MASK;
         end
         if (awaddr_r == CSSR_CFG_OFF) begin
            if (wstrb_r[0]) begin
               frq_r  <= wdata_r[2:0];
               mode_r <= wdata_r[6:4];
            end
            if (wstrb_r[1]) begin
               irq_en_r <= wdata_r[CSSR_IE_BIT];
            end
         end
      end
   end

   // Outputs to the oscillators, PLL and mux, all from flops.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         active_sel.src    <= CSSR_RST_SRC;
         active_sel.div    <= CSSR_RST_DIV_HF;
         pll_input_src     <= CSSR_SRC_HF;
         osc_force_on      <= CSSR_RST_EN;
         internal_freq_sel <= CSSR_RST_FRQ;
         ext_osc_mode_cfg  <= CSSR_RST_MODE;
         switch_irq        <= 1'b0;
      end else begin
         active_sel        <= cur_r;
         // PLL input follows the request when it picks a PLL source.
         if (req_r.src == CSSR_SRC_EXT_PLL) begin
            pll_input_src <= CSSR_SRC_EXT;
         end else if (req_r.src == CSSR_SRC_HF_PLL) begin
            pll_input_src <= CSSR_SRC_HF;
         end
         osc_force_on      <= en_r;
         internal_freq_sel <= frq_r;
         ext_osc_mode_cfg  <= mode_r;
         switch_irq        <= irq_flag_r && irq_en_r;
      end
   end

   // Status image from synchronised ready lines.
   always_comb begin
      stat_byte               = 8'h00;
      stat_byte[CSSR_EXT_BIT] = rdy_r.ext;
      stat_byte[CSSR_HF_BIT]  = rdy_r.hf;
      stat_byte[CSSR_MF_BIT]  = rdy_r.mf;
      stat_byte[CSSR_LF_BIT]  = rdy_r.lf;
      stat_byte[CSSR_RC_BIT]  = rdy_r.rc;
      stat_byte[CSSR_PLL_BIT] = pll_ok;
   end

   // Read mux; unmapped addresses answer SLVERR with zero data.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         CSSR_REQ_OFF:  rd_word[6:0] = {req_r.src, req_r.div};
         CSSR_CUR_OFF:  rd_word[6:0] = {cur_r.src, cur_r.div};
         CSSR_CTL_OFF: begin
            rd_word[CSSR_HOLD_BIT] = hold_r;
            rd_word[CSSR_DONE_BIT] = (req_r == cur_r);
            rd_word[CSSR_NEW_BIT]  = new_rdy_r;
         end
         CSSR_STAT_OFF: rd_word[7:0] = stat_byte;
         CSSR_EN_OFF:   rd_word[7:0] = en_r;
         CSSR_CFG_OFF:  rd_word[8:0] = {irq_en_r, 1'b0, mode_r, 1'b0, frq_r};
         CSSR_IRQ_OFF:  rd_word[0]   = irq_flag_r;
         default:       rd_ok        = 1'b0;
      endcase
   end

   // Write channels: address and data taken in any order, then respond.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         aw_hit_r      <= 1'b0;
         w_hit_r       <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= CSSR_OKAY;
      end else begin
         s_axi_awready <= !aw_hit_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hit_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hit_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hit_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r <= CSSR_IRQ_OFF && awaddr_r[1:0] == 2'h0
                             && awaddr_r != CSSR_CUR_OFF && awaddr_r != CSSR_STAT_OFF)
                            ? CSSR_OKAY : CSSR_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_hit_r     <= 1'b0;
            w_hit_r      <= 1'b0;
         end
      end
   end

   // Read channel: one cycle after the address handshake.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= CSSR_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? CSSR_OKAY : CSSR_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Current setting moves only in the cycle after a held-off or direct switch.
   property p_cur_stable;
      @(posedge clock) disable iff (!rst_sync_n)
         (state_r == CSSR_IDLE) |=> $stable(cur_r);
   endproperty
   a_cur_stable: assert property (p_cur_stable)
      else $error("Current setting changed outside a switch.");

   property p_hold_stalls;
      @(posedge clock) disable iff (!rst_sync_n)
         (state_r == CSSR_WAIT && req_rdy && hold_r && req_r != cur_r)
            |=> (new_rdy_r && irq_flag_r && $stable(cur_r));
   endproperty
   a_hold_stalls: assert property (p_hold_stalls)
      else $error("Held switch did not stall with flags set.");

   property p_switch_go;
      @(posedge clock) disable iff (!rst_sync_n)
         (state_r == CSSR_WAIT && req_rdy && !hold_r && req_r != cur_r)
            |=> (cur_r == $past(req_r));
   endproperty
   a_switch_go: assert property (p_switch_go)
      else $error("Unheld ready switch did not take place.");

   property p_new_rdy;
      @(posedge clock) disable iff (!rst_sync_n)
         new_rdy_r |-> ($past(req_rdy) && $past(req_r) != $past(cur_r));
   endproperty
   a_new_rdy: assert property (p_new_rdy)
      else $error("New-ready flag set with no switch pending.");

   property p_irq_sets;
      @(posedge clock) disable iff (!rst_sync_n)
         ready_rise |=> irq_flag_r;
   endproperty
   a_irq_sets: assert property (p_irq_sets)
      else $error("Interrupt flag missed a ready event.");

   property p_irq_out;
      @(posedge clock) disable iff (!rst_sync_n)
         switch_irq |-> $past(irq_flag_r) && $past(irq_en_r);
   endproperty
   a_irq_out: assert property (p_irq_out)
      else $error("Interrupt raised without flag and enable.");

   property p_req_legal;
      @(posedge clock) disable iff (!rst_sync_n)
         !$stable(req_r) |-> ($past(src_ok) && req_r.div <= CSSR_DIV_MAX);
   endproperty
   a_req_legal: assert property (p_req_legal)
      else $error("Reserved request code was stored.");

   property p_en_mask;
      @(posedge clock) disable iff (!rst_sync_n)
         (osc_force_on & ~CSSR_EN_MASK) == 8'h00;
   endproperty
   a_en_mask: assert property (p_en_mask)
      else $error("Unimplemented enable bit is set.");

   property p_pll_flag;
      @(posedge clock) disable iff (!rst_sync_n)
         pll_ok |-> (lock_r && pllen_r);
   endproperty
   a_pll_flag: assert property (p_pll_flag)
      else $error("PLL ready without lock and enable.");
endmodule

// >>> cssr_osc_model.sv
// Behavioural oscillators and PLL facing the clock switch block.
// Assumes run requests are levels and ready comes back after settle cycles.
`timescale 1ns/100ps
module cssr_osc_model
   import cssr_pkg::*;
(
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Requests from the block and from other modules; bit 0 enables the PLL.
   input  wire logic [7:0] force_on,
   input  wire logic [7:0] other_req,
   input  wire logic [2:0] pll_src,
   input  wire logic [3:0] settle,
   // Ready levels back to the block.
   output cssr_ready_t     ready,
   output logic            pll_enabled,
   output logic            pll_locked
);
   logic [3:0] age_r [8];  // Cycles each oscillator has been running.
   logic [7:0] ok;         // Oscillator settled and usable.
   // An oscillator runs while forced or requested; a large settle makes it slow.
   always_ff @(posedge clock or negedge rst_n) begin
      for (int i = 0; i < 8; i++) begin
         if (!rst_n || !(force_on[i] | other_req[i])) age_r[i] <= 4'h0;
         else if (age_r[i] != 4'hF) age_r[i] <= age_r[i] + 4'h1;
      end
   end
   // Ready drops at once when the oscillator stops, as a real one would.
   always_comb begin
      for (int i = 0; i < 8; i++) ok[i] = (force_on[i] | other_req[i]) && age_r[i] > settle;
   end
   assign ready = {ok[7], ok[6], ok[5], ok[4], ok[2], ok[0]};
   assign pll_enabled = other_req[0];
   // Lock needs the chosen input oscillator as well.
   assign pll_locked = ok[0] && ok[pll_src == CSSR_SRC_EXT ? 7 : 6];
endmodule

// >>> clock_switch_status_regs_test.sv
// Self-checking bench for the clock switch registers over AXI4-Lite.
// Assumes the oscillator model answers force-on requests after settle cycles.
`timescale 1ns/100ps
module clock_switch_status_regs_test
   import cssr_pkg::*;
;
   logic          clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic          awready, wready, bvalid, arready, rvalid, pll_en, pll_lk, irq;
   logic [7:0]    awaddr, araddr, other_req, force_on;
   logic [31:0]   wdata, rdata, rd_v;
   logic [3:0]    wstrb, settle;
   logic [1:0]    bresp, rresp, rs_v, wr_v;
   logic [2:0]    pll_src, frq, mode;
   logic [6:0]    nv, cur, old;
   cssr_ready_t   rdy;
   cssr_setting_t act;
   int            mismatches, compares;
   cssr_top uut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .osc_ready_raw(rdy), .pll_enabled(pll_en), .pll_locked(pll_lk), .active_sel(act),
      .pll_input_src(pll_src), .osc_force_on(force_on), .internal_freq_sel(frq),
      .ext_osc_mode_cfg(mode), .switch_irq(irq));
   cssr_osc_model osc (.clock(clock), .rst_n(rst_n), .force_on(force_on), .other_req(other_req),
      .pll_src(pll_src), .settle(settle), .ready(rdy), .pll_enabled(pll_en), .pll_locked(pll_lk));
   // Free-running 25 MHz clock.
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded waits end the run rather than hang it.
   task automatic give_up;
      mismatches++;
      $display("BAD %0t handshake never answered", $time);
      wrap_up();
   endtask
   // One write; address and data offered together, each released when taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 60);
      wr_v = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1) give_up();
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 60);
      rd_v = rdata;
      rs_v = rresp;
      rready <= 1'b0;
      if (rvalid !== 1'b1) give_up();
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk(rd_v, e);
   endtask
   // Polls one control bit until it reads high.
   task automatic poll(input int b);
      for (int k = 0; k < 40; k++) begin
         axr(CSSR_CTL_OFF);
         if (rd_v[b] === 1'b1) return;
      end
      give_up();
   endtask
   // A request is kept only with a listed source and a divider up to 512.
   function automatic logic legal(input logic [6:0] v);
      return v[6:4] inside {CSSR_SRC_EXT, CSSR_SRC_HF, CSSR_SRC_LF, CSSR_SRC_EXT_PLL,
         CSSR_SRC_HF_PLL} && v[3:0] <= CSSR_DIV_MAX;
   endfunction
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
      {wdata, wstrb, other_req} = '0;
      settle = 4'h3;
      mismatches = 0;
      compares = 0;
      void'($urandom(32'h8fc5));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      cur = {CSSR_RST_SRC, CSSR_RST_DIV_HF};
      rd_chk(CSSR_CUR_OFF, 32'(cur));
      rd_chk(CSSR_CTL_OFF, 32'h10);
      rd_chk(CSSR_EN_OFF, 32'h0);
      rd_chk(CSSR_STAT_OFF, 32'h0);
      axw(CSSR_EN_OFF, 32'hFFFFFFFF, 4'hF);
      rd_chk(CSSR_EN_OFF, 32'hF4);
      chk(32'(force_on), 32'hF4);
      repeat (10) @(posedge clock);
      rd_chk(CSSR_STAT_OFF, 32'hF4);
      other_req <= 8'h01;
      repeat (10) @(posedge clock);
      rd_chk(CSSR_STAT_OFF, 32'hF5);
      axw(CSSR_CUR_OFF, 32'h0, 4'hF);
      chk(32'(wr_v), 32'(CSSR_SLVERR));
      axr(8'h1C);
      chk(32'(rs_v), 32'(CSSR_SLVERR));
      chk(rd_v, 32'h0);
      // Every source code once, then random requests; reserved ones must vanish.
      for (int i = 0; i < 14; i++) begin
         nv = (i < 8) ? {3'(i), 4'($urandom % 11)} : 7'($urandom);
         axw(CSSR_REQ_OFF, 32'(nv), 4'h1);
         if (legal(nv)) cur = nv;
         poll(CSSR_DONE_BIT);
         rd_chk(CSSR_CUR_OFF, 32'(cur));
         rd_chk(CSSR_REQ_OFF, 32'(cur));
         chk(32'(act), 32'(cur));
         if (cur[6:4] == CSSR_SRC_EXT_PLL) chk(32'(pll_src), 32'(CSSR_SRC_EXT));
         if (cur[6:4] == CSSR_SRC_HF_PLL) chk(32'(pll_src), 32'(CSSR_SRC_HF));
      end
      // Held switch with the interrupt enabled, then released.
      axw(CSSR_CFG_OFF, 32'h135, 4'h3);
      // The config outputs are flops one cycle behind the register; let them settle.
      repeat (2) @(posedge clock);
      chk({29'h0, frq}, 32'h5);
      chk({29'h0, mode}, 32'h3);
      axw(CSSR_IRQ_OFF, 32'h1, 4'h1);
      axw(CSSR_CTL_OFF, 32'h80, 4'h1);
      old = cur;
      cur = (cur == 7'h51) ? 7'h70 : 7'h51;
      axw(CSSR_REQ_OFF, 32'(cur), 4'h1);
      poll(CSSR_NEW_BIT);
      rd_chk(CSSR_CUR_OFF, 32'(old));
      rd_chk(CSSR_CTL_OFF, 32'h88);
      rd_chk(CSSR_IRQ_OFF, 32'h1);
      chk(32'(irq), 32'h1);
      axw(CSSR_CTL_OFF, 32'h0, 4'h1);
      poll(CSSR_DONE_BIT);
      rd_chk(CSSR_CUR_OFF, 32'(cur));
      rd_chk(CSSR_CTL_OFF, 32'h10);
      axw(CSSR_IRQ_OFF, 32'h1, 4'h1);
      rd_chk(CSSR_IRQ_OFF, 32'h0);
      chk(32'(irq), 32'h0);
      wrap_up();
   end
endmodule
